// ===== rtl/dmd_datapath.sv
// Multiply datapath top: pipeline port, APB status registers
//
// The register offsets and the APB slave port are this design's own decisions.
module dmd_datapath (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // APB slave
  input  wire logic             psel_i,
  input  wire logic             penable_i,
  input  wire logic             pwrite_i,
  input  wire logic [7:0]       paddr_i,
  input  wire logic [31:0]      pwdata_i,
  output logic      [31:0]      prdata_o,
  output logic                  pready_o,
  output logic                  pslverr_o,
  // Request from the decoder
  input  wire logic             req_i,
  input  wire dmd_pkg::dmd_op_t op_i,
  input  wire logic             round_i,
  input  wire logic             cond_pass_i,
  input  wire logic [31:0]      first_operand_i,
  input  wire logic [31:0]      second_operand_i,
  input  wire logic [31:0]      addend_source_i,
  input  wire logic [31:0]      upper_result_word_i,
  input  wire logic [31:0]      lower_result_word_i,
  // Writeback to the register file
  output logic                  done_o,
  output logic                  wr_dest_o,
  output logic                  wr_upper_o,
  output logic                  wr_lower_o,
  output logic      [31:0]      result_o,
  output logic      [31:0]      upper_result_word_o,
  output logic                  sticky_ovf_o
);
  import dmd_pkg::*;

  dmd_mul_if  mif ();
  dmd_state_t st;
  dmd_state_t next_st;
  logic       take;
  logic       exec;
  logic       apb_wr;
  logic       apb_setup_rd;
  logic       addr_hit;

  // Operands go straight to the arithmetic; results land in flops
  assign mif.op     = op_i;
  assign mif.round  = round_i;
  assign mif.a      = first_operand_i;
  assign mif.b      = second_operand_i;
  assign mif.ra     = addend_source_i;
  assign mif.acc_hi = upper_result_word_i;
  assign mif.acc_lo = lower_result_word_i;

  dmd_mul_arith u_arith (
    .m (mif.arith)
  );

  // Bus decode; the slave answers in the first access cycle
  always_comb begin
    addr_hit = (paddr_i == DMD_ADDR_STATUS) || (paddr_i == DMD_ADDR_CTRL) ||
               (paddr_i == DMD_ADDR_RESULT_LO) ||
               (paddr_i == DMD_ADDR_RESULT_HI);
    apb_wr       = psel_i && penable_i && pwrite_i && addr_hit;
    apb_setup_rd = psel_i && !penable_i && !pwrite_i;
    take         = req_i && st.enable;
    exec         = take && cond_pass_i;
  end

  // Next state; a disabled block ignores requests entirely
  always_comb begin
    next_st          = st;
    next_st.done     = take;
    next_st.wr_dest  = exec && mif.wr_dest;
    next_st.wr_upper = exec && mif.wr_long;
    next_st.wr_lower = exec && mif.wr_long;
    if (exec) begin
      next_st.res_lo = mif.lo;
      next_st.res_hi = mif.hi;
    end
    if (apb_wr && paddr_i == DMD_ADDR_CTRL) begin
      next_st.enable = pwdata_i[DMD_CTRL_EN_BIT];
    end
    // Software write first, so a same-cycle overflow still sets it
    if (apb_wr && paddr_i == DMD_ADDR_STATUS) begin
      next_st.sticky = pwdata_i[DMD_STATUS_OVF_BIT];
    end
    if (exec && mif.ovf) begin
      next_st.sticky = 1'b1;
    end
    // Read data captured in the setup cycle, held through access
    if (apb_setup_rd) begin
      case (paddr_i)
        DMD_ADDR_STATUS:    next_st.rdata = {31'h0000_0000, st.sticky};
        DMD_ADDR_CTRL:      next_st.rdata = {31'h0000_0000, st.enable};
        DMD_ADDR_RESULT_LO: next_st.rdata = st.res_lo;
        DMD_ADDR_RESULT_HI: next_st.rdata = st.res_hi;
        default:            next_st.rdata = 32'h0000_0000;
      endcase
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st        <= '0;
      st.enable <= DMD_CTRL_EN_RESET;
    end else begin
      st <= next_st;
    end
  end

  // Outputs
  assign prdata_o            = st.rdata;
  assign pready_o            = psel_i && penable_i;
  assign pslverr_o           = psel_i && penable_i && !addr_hit;
  assign done_o              = st.done;
  assign wr_dest_o           = st.wr_dest;
  assign wr_upper_o          = st.wr_upper;
  assign wr_lower_o          = st.wr_lower;
  assign result_o            = st.res_lo;
  assign upper_result_word_o = st.res_hi;
  assign sticky_ovf_o        = st.sticky;

  // Reference values for the checks below
  logic [63:0] ref_s;
  logic [63:0] ref_r;
  logic        status_wr;
  assign ref_s     = dmd_mul_s32(first_operand_i, second_operand_i);
  assign ref_r     = ref_s + DMD_ROUND_CONST;
  assign status_wr = apb_wr && paddr_i == DMD_ADDR_STATUS;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_round_msw;
    take && cond_pass_i && op_i == DMD_OP_MSW_MULTIPLY && round_i
      |=> wr_dest_o && result_o == $past(ref_r[63:32]);
  endproperty
  a_round_msw: assert property (p_round_msw)
    else $error("rounded upper word wrong");

  property p_msw_acc;
    take && cond_pass_i && op_i == DMD_OP_MSW_MUL_ACCUMULATE && !round_i
      |=> result_o == $past(ref_s[63:32] + addend_source_i);
  endproperty
  a_msw_acc: assert property (p_msw_acc)
    else $error("upper word accumulate wrong");

  property p_msw_sub;
    take && cond_pass_i && op_i == DMD_OP_MSW_MUL_SUBTRACT && !round_i
      |=> result_o == $past(addend_source_i - ref_s[63:32]);
  endproperty
  a_msw_sub: assert property (p_msw_sub)
    else $error("upper word subtract wrong");

  property p_msw_trunc;
    take && cond_pass_i && op_i == DMD_OP_MSW_MULTIPLY && !round_i
      |=> result_o == $past(ref_s[63:32]);
  endproperty
  a_msw_trunc: assert property (p_msw_trunc)
    else $error("truncated upper word wrong");

  property p_flags_kept;
    take && !(op_i == DMD_OP_DUAL_HALF_MUL_ADD ||
              op_i == DMD_OP_DUAL_HALF_MUL_ADD_SWAPPED) && !status_wr
      |=> $stable(sticky_ovf_o);
  endproperty
  a_flags_kept: assert property (p_flags_kept)
    else $error("flag changed by non-overflowing op");

  property p_dual_sub;
    take && cond_pass_i && op_i == DMD_OP_DUAL_HALF_MUL_SUB
      |=> result_o == $past(
            dmd_mul_s16(first_operand_i[15:0], second_operand_i[15:0]) -
            dmd_mul_s16(first_operand_i[31:16], second_operand_i[31:16]));
  endproperty
  a_dual_sub: assert property (p_dual_sub)
    else $error("dual subtract wrong");

  property p_dual_swap;
    take && cond_pass_i && op_i == DMD_OP_DUAL_HALF_MUL_ADD_SWAPPED
      |=> result_o == $past(
            dmd_mul_s16(first_operand_i[15:0], second_operand_i[31:16]) +
            dmd_mul_s16(first_operand_i[31:16], second_operand_i[15:0]));
  endproperty
  a_dual_swap: assert property (p_dual_swap)
    else $error("swapped dual add wrong");

  property p_ovf_set;
    exec && mif.ovf |=> sticky_ovf_o [*2];
  endproperty
  a_ovf_set: assert property (p_ovf_set)
    else $error("overflow did not stick");

  property p_clear_only_sw;
    $fell(sticky_ovf_o) |-> $past(status_wr);
  endproperty
  a_clear_only_sw: assert property (p_clear_only_sw)
    else $error("sticky flag cleared without write");

  property p_half_hl;
    take && cond_pass_i && op_i == DMD_OP_HALF_MUL_HIGH_LOW
      |=> result_o == $past(dmd_mul_s16(first_operand_i[31:16],
                                        second_operand_i[15:0]));
  endproperty
  a_half_hl: assert property (p_half_hl)
    else $error("halfword select wrong");

  property p_slong;
    take && cond_pass_i && op_i == DMD_OP_SIGNED_LONG_PRODUCT
      |=> {upper_result_word_o, result_o} == $past(ref_s);
  endproperty
  a_slong: assert property (p_slong)
    else $error("signed long product wrong");

  property p_cond_false;
    take && !cond_pass_i
      |=> done_o && !wr_dest_o && !wr_upper_o && !wr_lower_o &&
          ($stable(sticky_ovf_o) || $past(status_wr));
  endproperty
  a_cond_false: assert property (p_cond_false)
    else $error("write despite failed condition");

  property p_done_pair;
    take ##1 1'b1 |-> done_o && (wr_upper_o == wr_lower_o);
  endproperty
  a_done_pair: assert property (p_done_pair)
    else $error("done or long word pair wrong");

  c_overflow: cover property (exec && mif.ovf ##1 sticky_ovf_o);
  c_long_mac: cover property (take && op_i == DMD_OP_SIGNED_LONG_MAC
                              ##1 wr_upper_o);
  c_skip:     cover property (take && !cond_pass_i ##1 done_o);
  c_clear:    cover property (sticky_ovf_o ##1 !sticky_ovf_o);

endmodule : dmd_datapath

// ===== rtl/dmd_pkg.sv
// What this block does
// - Rounding adds 0x80000000 before upper word
// - Upper product word plus addend source
// - Addend source minus upper product word
// - Upper signed product word, truncated or rounded
// - Long and upper-word ops leave flags unchanged
// - Swap option exchanges second operand halfwords
// - Dual multiply-add sums two halfword products
// - Dual subtract: bottom product minus top product
// - Dual add overflow sets sticky overflow flag
// - Sticky flag cleared only by software write
// - Halfword select picks bottom or top bits
// - Halfword multiply writes full 32-bit product
// - Word by halfword writes upper 32 of 48
// - Long multiply writes low and high words
// - Unsigned long accumulate adds 64-bit pair
// - Signed long accumulate adds 64-bit pair
// - Double accumulate adds both result words
package dmd_pkg;

  // Operation codes from the instruction decoder
  typedef enum logic [4:0] {
    DMD_OP_MSW_MULTIPLY               = 5'h00,
    DMD_OP_MSW_MUL_ACCUMULATE         = 5'h01,
    DMD_OP_MSW_MUL_SUBTRACT           = 5'h02,
    DMD_OP_DUAL_HALF_MUL_ADD          = 5'h03,
    DMD_OP_DUAL_HALF_MUL_ADD_SWAPPED  = 5'h04,
    DMD_OP_DUAL_HALF_MUL_SUB          = 5'h05,
    DMD_OP_DUAL_HALF_MUL_SUB_SWAPPED  = 5'h06,
    DMD_OP_HALF_MUL_LOW_LOW           = 5'h07,
    DMD_OP_HALF_MUL_LOW_HIGH          = 5'h08,
    DMD_OP_HALF_MUL_HIGH_LOW          = 5'h09,
    DMD_OP_HALF_MUL_HIGH_HIGH         = 5'h0a,
    DMD_OP_WORD_BY_LOW_HALF_MUL       = 5'h0b,
    DMD_OP_WORD_BY_HIGH_HALF_MUL      = 5'h0c,
    DMD_OP_UNSIGNED_LONG_PRODUCT      = 5'h0d,
    DMD_OP_UNSIGNED_LONG_MAC          = 5'h0e,
    DMD_OP_UNSIGNED_LONG_DOUBLE_ACC   = 5'h0f,
    DMD_OP_SIGNED_LONG_PRODUCT        = 5'h10,
    DMD_OP_SIGNED_LONG_MAC            = 5'h11
  } dmd_op_t;

  // Register map, byte addresses on the APB
  localparam logic [7:0]  DMD_ADDR_STATUS    = 8'h00;
  localparam logic [7:0]  DMD_ADDR_CTRL      = 8'h04;
  localparam logic [7:0]  DMD_ADDR_RESULT_LO = 8'h08;
  localparam logic [7:0]  DMD_ADDR_RESULT_HI = 8'h0c;
  localparam int          DMD_STATUS_OVF_BIT = 0;
  localparam int          DMD_CTRL_EN_BIT    = 0;
  localparam logic        DMD_CTRL_EN_RESET  = 1'b1;
  localparam logic [63:0] DMD_ROUND_CONST    = 64'h0000_0000_8000_0000;

  // Registered state of the top module
  typedef struct packed {
    logic        sticky;
    logic        enable;
    logic        done;
    logic        wr_dest;
    logic        wr_upper;
    logic        wr_lower;
    logic [31:0] res_lo;
    logic [31:0] res_hi;
    logic [31:0] rdata;
  } dmd_state_t;

  // Signed 32x32, full 64-bit product
  function automatic logic [63:0] dmd_mul_s32(input logic [31:0] a,
                                              input logic [31:0] b);
    logic signed [63:0] x;
    logic signed [63:0] y;
    x = {{32{a[31]}}, a};
    y = {{32{b[31]}}, b};
    return 64'(x * y);
  endfunction : dmd_mul_s32

  // Unsigned 32x32, full 64-bit product
  function automatic logic [63:0] dmd_mul_u32(input logic [31:0] a,
                                              input logic [31:0] b);
    return 64'({32'h0000_0000, a} * {32'h0000_0000, b});
  endfunction : dmd_mul_u32

  // Signed 16x16; every product fits in 32 bits
  function automatic logic [31:0] dmd_mul_s16(input logic [15:0] a,
                                              input logic [15:0] b);
    return 32'(dmd_mul_s32({{16{a[15]}}, a}, {{16{b[15]}}, b}));
  endfunction : dmd_mul_s16

  // Halfword pick: top half or bottom half
  function automatic logic [15:0] dmd_half(input logic [31:0] w,
                                           input logic        top);
    return top ? w[31:16] : w[15:0];
  endfunction : dmd_half

endpackage : dmd_pkg

// ===== rtl/dmd_mul_if.sv
// Operands in, results out, between control and arithmetic
interface dmd_mul_if;
  import dmd_pkg::*;
  dmd_op_t     op;
  logic        round;
  logic [31:0] a;
  logic [31:0] b;
  logic [31:0] ra;
  logic [31:0] acc_hi;
  logic [31:0] acc_lo;
  logic [31:0] lo;
  logic [31:0] hi;
  logic        wr_dest;
  logic        wr_long;
  logic        ovf;

  modport arith (input  op, round, a, b, ra, acc_hi, acc_lo,
                 output lo, hi, wr_dest, wr_long, ovf);
  modport ctrl  (output op, round, a, b, ra, acc_hi, acc_lo,
                 input  lo, hi, wr_dest, wr_long, ovf);
endinterface : dmd_mul_if

// ===== rtl/dmd_mul_arith.sv
// Pure combinational arithmetic for all multiply variants
module dmd_mul_arith (
  // Operand and result bundle
  dmd_mul_if.arith m
);
  import dmd_pkg::*;

  logic [63:0] prod_s;
  logic [63:0] prod_u;
  logic [63:0] rnd_sum;
  logic [31:0] msw;
  logic [15:0] b_pair_bot;
  logic [15:0] b_pair_top;
  logic [15:0] w_half;
  logic [31:0] p_bot;
  logic [31:0] p_top;
  logic [32:0] dsum;
  logic [63:0] acc64;
  logic [63:0] wprod;

  // Shared products; two wide signed, one unsigned and two halfword multipliers
  always_comb begin
    prod_s     = dmd_mul_s32(m.a, m.b);
    prod_u     = dmd_mul_u32(m.a, m.b);
    rnd_sum    = prod_s + (m.round ? DMD_ROUND_CONST : 64'h0000_0000_0000_0000);
    msw        = rnd_sum[63:32];
    b_pair_bot = dmd_half(m.b, m.op == DMD_OP_DUAL_HALF_MUL_ADD_SWAPPED ||
                               m.op == DMD_OP_DUAL_HALF_MUL_SUB_SWAPPED);
    b_pair_top = dmd_half(m.b, !(m.op == DMD_OP_DUAL_HALF_MUL_ADD_SWAPPED ||
                                 m.op == DMD_OP_DUAL_HALF_MUL_SUB_SWAPPED));
    p_bot      = dmd_mul_s16(m.a[15:0], b_pair_bot);
    p_top      = dmd_mul_s16(m.a[31:16], b_pair_top);
    dsum       = {p_bot[31], p_bot} + {p_top[31], p_top};
    acc64      = {m.acc_hi, m.acc_lo};
    // Halfword held in a variable; a call result cannot be bit-selected
    w_half     = dmd_half(m.b, m.op == DMD_OP_WORD_BY_HIGH_HALF_MUL);
    wprod      = dmd_mul_s32(m.a, {{16{w_half[15]}}, w_half});
  end

  // Result select per operation
  always_comb begin
    m.lo      = 32'h0000_0000;
    m.hi      = 32'h0000_0000;
    m.wr_dest = 1'b0;
    m.wr_long = 1'b0;
    m.ovf     = 1'b0;
    case (m.op)
      DMD_OP_MSW_MULTIPLY: begin
        m.lo      = msw;
        m.wr_dest = 1'b1;
      end
      DMD_OP_MSW_MUL_ACCUMULATE: begin
        m.lo      = msw + m.ra;
        m.wr_dest = 1'b1;
      end
      DMD_OP_MSW_MUL_SUBTRACT: begin
        m.lo      = m.ra - msw;
        m.wr_dest = 1'b1;
      end
      DMD_OP_DUAL_HALF_MUL_ADD, DMD_OP_DUAL_HALF_MUL_ADD_SWAPPED: begin
        m.lo      = dsum[31:0];
        m.ovf     = dsum[32] ^ dsum[31];
        m.wr_dest = 1'b1;
      end
      DMD_OP_DUAL_HALF_MUL_SUB, DMD_OP_DUAL_HALF_MUL_SUB_SWAPPED: begin
        m.lo      = p_bot - p_top;
        m.wr_dest = 1'b1;
      end
      DMD_OP_HALF_MUL_LOW_LOW, DMD_OP_HALF_MUL_LOW_HIGH,
      DMD_OP_HALF_MUL_HIGH_LOW, DMD_OP_HALF_MUL_HIGH_HIGH: begin
        m.lo      = dmd_mul_s16(
          dmd_half(m.a, m.op == DMD_OP_HALF_MUL_HIGH_LOW ||
                        m.op == DMD_OP_HALF_MUL_HIGH_HIGH),
          dmd_half(m.b, m.op == DMD_OP_HALF_MUL_LOW_HIGH ||
                        m.op == DMD_OP_HALF_MUL_HIGH_HIGH));
        m.wr_dest = 1'b1;
      end
      DMD_OP_WORD_BY_LOW_HALF_MUL, DMD_OP_WORD_BY_HIGH_HALF_MUL: begin
        m.lo      = wprod[47:16];
        m.wr_dest = 1'b1;
      end
      DMD_OP_UNSIGNED_LONG_PRODUCT: begin
        {m.hi, m.lo} = prod_u;
        m.wr_long    = 1'b1;
      end
      DMD_OP_SIGNED_LONG_PRODUCT: begin
        {m.hi, m.lo} = prod_s;
        m.wr_long    = 1'b1;
      end
      DMD_OP_UNSIGNED_LONG_MAC: begin
        {m.hi, m.lo} = prod_u + acc64;
        m.wr_long    = 1'b1;
      end
      DMD_OP_SIGNED_LONG_MAC: begin
        {m.hi, m.lo} = prod_s + acc64;
        m.wr_long    = 1'b1;
      end
      DMD_OP_UNSIGNED_LONG_DOUBLE_ACC: begin
        {m.hi, m.lo} = prod_u + {32'h0000_0000, m.acc_hi}
                              + {32'h0000_0000, m.acc_lo};
        m.wr_long    = 1'b1;
      end
      default: begin
        m.lo = 32'h0000_0000;
      end
    endcase
  end

endmodule : dmd_mul_arith

// ===== tb/dmd_core_model.sv
// Decoder and register file facing the multiply datapath
module dmd_core_model (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // Bench commands: register load or issue
  input  wire logic             load_i,
  input  wire logic [3:0]       load_idx_i,
  input  wire logic [31:0]      load_val_i,
  input  wire logic             issue_i,
  input  wire dmd_pkg::dmd_op_t cmd_op_i,
  input  wire logic             cmd_round_i,
  input  wire logic             cmd_cond_i,
  input  wire logic [19:0]      idx_i,
  // Request to the datapath
  output logic                  req_o,
  output dmd_pkg::dmd_op_t      op_o,
  output logic                  round_o,
  output logic                  cond_o,
  output logic      [31:0]      rn_o,
  output logic      [31:0]      rm_o,
  output logic      [31:0]      ra_o,
  output logic      [31:0]      hi_o,
  output logic      [31:0]      lo_o,
  // Writeback from the datapath
  input  wire logic             wr_dest_i,
  input  wire logic             wr_upper_i,
  input  wire logic             wr_lower_i,
  input  wire logic [31:0]      res_i,
  input  wire logic [31:0]      up_i
);
  timeunit 1ns;
  timeprecision 1ps;
  import dmd_pkg::*;

  logic [31:0] regs [16];
  logic [3:0]  dst_lo;
  logic [3:0]  dst_hi;
  logic        ok;

  // Index order: first, second, addend, lower, upper
  always_comb begin
    ok = idx_i[7:4] != idx_i[3:0];
    for (int k = 0; k < 5; k++) begin
      if (idx_i[k*4 +: 4] inside {4'd13, 4'd15}) ok = 1'b0;
    end
  end

  // Operands flip to their inverse on each idle cycle, so stale data looks valid only on alternate cycles
  always @(posedge clk_i) begin
    req_o <= 1'b0;
    {rn_o, rm_o, ra_o, hi_o, lo_o} <= ~{rn_o, rm_o, ra_o, hi_o, lo_o};
    if (load_i) regs[load_idx_i] <= load_val_i;
    if (issue_i && ok && !rst_i) begin
      req_o   <= 1'b1;
      op_o    <= cmd_op_i;
      round_o <= cmd_round_i;
      cond_o  <= cmd_cond_i;
      rn_o    <= regs[idx_i[19:16]];
      rm_o    <= regs[idx_i[15:12]];
      ra_o    <= regs[idx_i[11:8]];
      lo_o    <= regs[idx_i[7:4]];
      hi_o    <= regs[idx_i[3:0]];
      dst_lo  <= idx_i[7:4];
      dst_hi  <= idx_i[3:0];
    end
    if (wr_dest_i || wr_lower_i) regs[dst_lo] <= res_i;
    if (wr_upper_i) regs[dst_hi] <= up_i;
  end
endmodule : dmd_core_model

// ===== tb/test_dmd_datapath.sv
// Self-checking bench for the multiply datapath
module test_dmd_datapath;
  timeunit 1ns;
  timeprecision 1ps;
  import dmd_pkg::*;

  logic        clk_i, rst_i, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, apb_rd, rn, rm, ra, hi_in, lo_in;
  logic [31:0] res, up, lval, exp_lo, exp_hi;
  logic        req, rnd, cond, done, wr_dest, wr_up, wr_lo, sticky;
  logic        load, issue, c_rnd, c_cond, apb_err;
  logic        exp_sticky, hi_valid, enabled;
  dmd_op_t     op, c_op;
  logic [3:0]  lidx;
  int          err_count, tests_run;
  logic [31:0] corner [6] = '{32'h8000_0000, 32'h7fff_ffff, 32'hffff_ffff,
                              32'h0000_0000, 32'h8000_8000, 32'h7fff_8001};

  dmd_datapath u_dmd_datapath (
    .clk_i(clk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .req_i(req), .op_i(op), .round_i(rnd), .cond_pass_i(cond),
    .first_operand_i(rn), .second_operand_i(rm), .addend_source_i(ra),
    .upper_result_word_i(hi_in), .lower_result_word_i(lo_in),
    .done_o(done), .wr_dest_o(wr_dest), .wr_upper_o(wr_up),
    .wr_lower_o(wr_lo), .result_o(res), .upper_result_word_o(up),
    .sticky_ovf_o(sticky));

  dmd_core_model u_dmd_core_model (
    .clk_i(clk_i), .rst_i(rst_i), .load_i(load), .load_idx_i(lidx),
    .load_val_i(lval), .issue_i(issue), .cmd_op_i(c_op),
    .cmd_round_i(c_rnd), .cmd_cond_i(c_cond), .idx_i(20'h1_2345),
    .req_o(req), .op_o(op), .round_o(rnd), .cond_o(cond), .rn_o(rn),
    .rm_o(rm), .ra_o(ra), .hi_o(hi_in), .lo_o(lo_in),
    .wr_dest_i(wr_dest), .wr_upper_i(wr_up), .wr_lower_i(wr_lo),
    .res_i(res), .up_i(up));

  // Free-running core clock
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic report_and_stop();
    $display("Checks %0d, errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : report_and_stop

  task automatic check(input string what, input logic [31:0] e,
                       input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h got %h", what, e, g);
    end
  endtask : check

  // Reference results: {overflow, upper word, lower word}
  function automatic logic [64:0] expect_op(input dmd_op_t o,
      input logic r, input logic [31:0] a, b, c, l, h);
    logic signed [63:0] sa, sb, p, w;
    logic signed [31:0] x0, x1, y0;
    logic [31:0]        bs;
    logic [15:0]        ha, hb;
    logic [32:0]        s;
    logic [63:0]        u;
    sa = $signed(a);
    sb = $signed(b);
    p  = sa * sb + (r ? DMD_ROUND_CONST : 64'h0000_0000_0000_0000);
    bs = (o inside {DMD_OP_DUAL_HALF_MUL_ADD_SWAPPED,
          DMD_OP_DUAL_HALF_MUL_SUB_SWAPPED}) ? {b[15:0], b[31:16]} : b;
    x0 = $signed(a[15:0]) * $signed(bs[15:0]);
    x1 = $signed(a[31:16]) * $signed(bs[31:16]);
    s  = {x0[31], x0} + {x1[31], x1};
    ha = (o inside {DMD_OP_HALF_MUL_HIGH_LOW, DMD_OP_HALF_MUL_HIGH_HIGH})
         ? a[31:16] : a[15:0];
    hb = (o inside {DMD_OP_HALF_MUL_LOW_HIGH, DMD_OP_HALF_MUL_HIGH_HIGH,
          DMD_OP_WORD_BY_HIGH_HALF_MUL}) ? b[31:16] : b[15:0];
    y0 = $signed(ha) * $signed(hb);
    w  = sa * $signed(hb);
    u  = {32'h0000_0000, a} * {32'h0000_0000, b};
    case (o)
      DMD_OP_MSW_MULTIPLY: return {33'd0, p[63:32]};
      DMD_OP_MSW_MUL_ACCUMULATE: return {33'd0, p[63:32] + c};
      DMD_OP_MSW_MUL_SUBTRACT: return {33'd0, c - p[63:32]};
      DMD_OP_DUAL_HALF_MUL_ADD, DMD_OP_DUAL_HALF_MUL_ADD_SWAPPED:
        return {s[32] ^ s[31], 32'd0, s[31:0]};
      DMD_OP_DUAL_HALF_MUL_SUB, DMD_OP_DUAL_HALF_MUL_SUB_SWAPPED:
        return {33'd0, x0 - x1};
      DMD_OP_WORD_BY_LOW_HALF_MUL, DMD_OP_WORD_BY_HIGH_HALF_MUL:
        return {33'd0, w[47:16]};
      DMD_OP_UNSIGNED_LONG_PRODUCT: return {1'b0, u};
      DMD_OP_UNSIGNED_LONG_MAC: return {1'b0, u + {h, l}};
      DMD_OP_UNSIGNED_LONG_DOUBLE_ACC: return {1'b0, u + h + l};
      DMD_OP_SIGNED_LONG_PRODUCT: return {1'b0, sa * sb};
      DMD_OP_SIGNED_LONG_MAC: return {1'b0, sa * sb + {h, l}};
      default: return {33'd0, y0};
    endcase
  endfunction : expect_op

  function automatic logic [31:0] pick();
    if ($urandom_range(0, 3) == 0) return corner[$urandom_range(0, 5)];
    return $urandom;
  endfunction : pick

  // One APB transfer; waits for pready under a bound
  task automatic apb(input logic w, input logic [7:0] ad,
                     input logic [31:0] wd);
    int n;
    @(posedge clk_i);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= ad;
    pwdata  <= wd;
    @(posedge clk_i);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready !== 1'b1 && n < 8);
    apb_rd  = prdata;
    apb_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n == 8) begin
      err_count++;
      report_and_stop();
    end
  endtask : apb

  // Load operands, issue, then compare the writeback
  task automatic run_op(input dmd_op_t o, input logic r, input logic cd,
                        input logic [31:0] x, y, z, l, h);
    logic [31:0] v [5] = '{x, y, z, l, h};
    logic [64:0] e;
    logic        lng;
    int          n;
    e   = expect_op(o, r, x, y, z, l, h);
    lng = o >= DMD_OP_UNSIGNED_LONG_PRODUCT;
    for (int k = 0; k < 5; k++) begin
      @(posedge clk_i);
      load <= 1'b1;
      lidx <= 4'(k + 1);
      lval <= v[k];
    end
    @(posedge clk_i);
    load   <= 1'b0;
    issue  <= 1'b1;
    c_op   <= o;
    c_rnd  <= r;
    c_cond <= cd;
    @(posedge clk_i);
    issue <= 1'b0;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (done !== 1'b1 && n < 8);
    if (!enabled) begin
      check("dropped", 32'd8, 32'(n));
      check("held res", exp_lo, res);
      return;
    end
    if (n == 8) begin
      err_count++;
      report_and_stop();
    end
    check("latency", 32'd2, 32'(n));
    check("writes", {29'd0, cd & !lng, cd & lng, cd & lng},
          {29'd0, wr_dest, wr_up, wr_lo});
    if (cd) begin
      exp_lo     = e[31:0];
      exp_hi     = e[63:32];
      hi_valid   = lng;
      exp_sticky = exp_sticky | e[64];
    end
    check("res", exp_lo, res);
    if (hi_valid) check("upper", exp_hi, up);
    check("sticky", {31'd0, exp_sticky}, {31'd0, sticky});
  endtask : run_op

  // Main sequence: reset, registers, sweeps, random traffic
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {load, lidx, lval, issue, c_rnd, c_cond} = '0;
    c_op = DMD_OP_MSW_MULTIPLY;
    {err_count, tests_run} = '0;
    {exp_lo, exp_hi, exp_sticky} = '0;
    hi_valid = 1'b1;
    enabled  = 1'b1;
    void'($urandom(85248));
    rst_i = 1'b1;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    apb(1'b0, DMD_ADDR_CTRL, 32'h0000_0000);
    check("ctrl", 32'h0000_0001, apb_rd);
    apb(1'b1, 8'h10, 32'hffff_ffff);
    check("slverr", 32'h0000_0001, {31'd0, apb_err});
    apb(1'b0, 8'h10, 32'h0000_0000);
    check("unmapped", 32'h0000_0001, {31'd0, apb_err});
    check("unmapped rd", 32'h0000_0000, apb_rd);
    apb(1'b1, DMD_ADDR_RESULT_LO, 32'h1234_5678);
    apb(1'b0, DMD_ADDR_RESULT_LO, 32'h0000_0000);
    check("ro result", 32'h0000_0000, apb_rd);
    // Every operation, truncated and rounded, on corner operands
    for (int i = 0; i < 36; i++) begin
      run_op(dmd_op_t'(5'(i / 2)), i[0], 1'b1, corner[i % 6],
             corner[(i + 1) % 6], corner[(i + 2) % 6], corner[i % 6],
             corner[(i + 3) % 6]);
    end
    // Overflow cleared, set by a dual add after a failed condition, then kept through a long accumulate
    apb(1'b1, DMD_ADDR_STATUS, 32'h0000_0000);
    exp_sticky = 1'b0;
    run_op(DMD_OP_DUAL_HALF_MUL_ADD, 1'b0, 1'b0, 32'h8000_8000,
           32'h8000_8000, 32'h0, 32'h0, 32'h0);
    run_op(DMD_OP_DUAL_HALF_MUL_ADD_SWAPPED, 1'b0, 1'b1, 32'h8000_8000,
           32'h8000_8000, 32'h0, 32'h0, 32'h0);
    run_op(DMD_OP_SIGNED_LONG_MAC, 1'b0, 1'b1, 32'h7fff_ffff,
           32'h7fff_ffff, 32'h0, 32'hffff_ffff, 32'h7fff_ffff);
    apb(1'b0, DMD_ADDR_STATUS, 32'h0000_0000);
    check("status", 32'h0000_0001, apb_rd);
    // Disabled datapath drops the request
    apb(1'b1, DMD_ADDR_CTRL, 32'h0000_0000);
    enabled = 1'b0;
    run_op(DMD_OP_MSW_MULTIPLY, 1'b0, 1'b1, 32'h1, 32'h2, 32'h3, 32'h4,
           32'h5);
    apb(1'b1, DMD_ADDR_CTRL, 32'h0000_0001);
    enabled = 1'b1;
    // Random traffic with periodic register reads and clears
    for (int i = 0; i < 300; i++) begin
      run_op(dmd_op_t'(5'($urandom_range(0, 17))),
             1'($urandom_range(0, 1)), $urandom_range(0, 7) != 0,
             pick(), pick(), pick(), pick(), pick());
      if (i % 25 == 0) begin
        apb(1'b0, DMD_ADDR_STATUS, 32'h0000_0000);
        check("status", {31'd0, exp_sticky}, apb_rd);
        apb(1'b0, DMD_ADDR_RESULT_LO, 32'h0000_0000);
        check("res reg", exp_lo, apb_rd);
        apb(1'b0, DMD_ADDR_RESULT_HI, 32'h0000_0000);
        if (hi_valid) check("upper reg", exp_hi, apb_rd);
      end
      if (i % 40 == 7) begin
        apb(1'b1, DMD_ADDR_STATUS, 32'h0000_0000);
        exp_sticky = 1'b0;
      end
    end
    report_and_stop();
  end
endmodule : test_dmd_datapath
